// ==== light_driver_model.sv ====
// model of the light driver on the far side of the drive outputs
// assumes clk_sys as reference; tone stands in for the free-running pll
`timescale 1ns/10ps
module light_driver_model (
   // clock and reset
   input  wire logic                    clk_sys,
   input  wire logic                    rst,
   // drive from the controller
   input  wire tof_mod_pkg::light_out_t light,
   // tone out and pulse count
   output logic                         tone,
   output logic [15:0]                  edges
);
   // ==========================================
   // tone: half the system rate, slow but enough to see toggling
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) tone <= 1'b0;
      else tone <= ~tone;
   end

   // ==========================================
   // pulses only count while the driver is switched active
   always @(posedge light.pos or posedge rst) begin
      if (rst) edges <= 16'h0;
      else if (light.active) edges <= edges + 16'h1;
   end
endmodule

// ==== testbench.sv ====
// testbench: apb-driven scenarios for the modulation controller
// assumes the package, checker and driver model are compiled first
`timescale 1ns/10ps
module testbench;
   // ==========================================
   // signals
   logic                    clk_sys, rst, psel, penable, pwrite, pready, pslverr;
   logic                    quad_start, readout_done, dealias_frame, tone, rerr;
   logic                    shutter_on, pixel_demod_en, pll_load, pdc, tdir;
   logic [7:0]              paddr, seqb, seqd;
   logic [31:0]             pwdata, prdata, rdat, ctrl_v;
   logic [15:0]             integ_cycles, edges;
   logic [5:0]              row_in, row_addr;
   logic [6:0]              col_in, col_addr;
   logic [3:0]              tsteps;
   logic [1:0]              phase_sel;
   logic [8:0]              phase_deg;
   logic [23:0]             eff_mult;
   tof_mod_pkg::light_out_t light;
   tof_mod_pkg::pll_cfg_t   pll_active;
   int                      failures = 0;
   int                      checks_done = 0;
   int                      qn = 0;

   tof_mod_ctrl #(.ROWS(60), .COLS(80)) DUT (
      .clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .quad_start, .integ_cycles, .readout_done, .dealias_frame, .row_in, .col_in, .row_addr,
      .col_addr, .tone, .shutter_on, .pixel_demod_en, .pixel_drive_dc_level(pdc), .light,
      .duty_trim_direction(tdir), .duty_trim_steps(tsteps), .phase_sel, .phase_deg, .pll_active,
      .eff_multiplier(eff_mult), .pll_load);
   light_driver_model drv (.clk_sys, .rst, .light, .tone, .edges);

   // ==========================================
   // clock and watchdog
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   initial begin
      #2000000;
      failures++;
      $display("[ERR] %0t watchdog expired", $time);
      stop_test();
   end

   // ==========================================
   // shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d, failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // one apb transfer; waits for pready, bounded by the watchdog
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys);
      while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic setctrl(input logic [31:0] v);
      ctrl_v = v;
      apb(1'b1, tof_mod_pkg::OFS_CTRL, v);
      repeat (2) @(negedge clk_sys);
   endtask
   // one full quad under the current control word
   task automatic quad();
      int n;
      logic [15:0] e0;
      logic [1:0] e;
      logic [7:0] sq;
      e = 2'(qn % 4) + ((ctrl_v[12] && qn[2]) ? ctrl_v[14:13] : 2'd0);
      @(posedge clk_sys);
      // sequence select read after the edge so a just-driven frame flag counts
      sq = dealias_frame ? seqd : seqb;
      quad_start <= 1'b1;
      @(posedge clk_sys);
      quad_start <= 1'b0;
      n = 1;
      while (light.active !== 1'b1 && n < 1000) begin
         @(posedge clk_sys);
         n++;
      end
      chk(ctrl_v[6] ? (n inside {[341:351]}) : (n inside {[716:726]}), 1);
      repeat (ctrl_v[6] ? 378 : 3) @(posedge clk_sys);
      e0 = edges;
      for (int i = 0; i < 8; i++) begin
         @(negedge clk_sys);
         if (ctrl_v[3]) chk({light.pos, light.neg}, {ctrl_v[4], ~ctrl_v[4]});
         else chk(light.neg, !light.pos);
      end
      chk(phase_sel, sq[2*e +: 2]);
      chk(phase_deg, 9'd90 * sq[2*e +: 2]);
      chk(shutter_on, 1'b1);
      chk(pixel_demod_en, !ctrl_v[3]);
      chk((edges - e0) >= 16'd3, !ctrl_v[3]);
      n = 0;
      while (light.active !== 1'b0 && n < 200) begin
         @(posedge clk_sys);
         n++;
      end
      repeat (2) @(negedge clk_sys);
      chk(shutter_on, !ctrl_v[2]);
      @(posedge clk_sys);
      readout_done <= 1'b1;
      @(posedge clk_sys);
      readout_done <= 1'b0;
      repeat (2) @(negedge clk_sys);
      chk(shutter_on, !ctrl_v[2]);
      chk({light.pos, light.neg, light.active}, 3'b010);
      qn++;
   endtask

   // ==========================================
   // scenarios
   task automatic t_regs();
      apb(1'b0, tof_mod_pkg::OFS_CTRL, 32'h0);
      chk(rdat, 32'h0);
      apb(1'b0, tof_mod_pkg::OFS_PLL, 32'h0);
      chk(rdat, 32'h0001_0110);
      apb(1'b0, tof_mod_pkg::OFS_FRAC, 32'h0);
      chk(rdat, 32'h0);
      chk(pll_active, {8'h10, 16'h0, 4'h1, 4'h1});
      apb(1'b0, 8'h1c, 32'h0);
      chk(rerr, 1'b1);
      chk(rdat, 32'h0);
      $display("register reset test done");
   endtask
   task automatic t_mirror();
      setctrl(32'h3);
      @(posedge clk_sys);
      row_in <= 6'd5;
      col_in <= 7'd7;
      repeat (2) @(negedge clk_sys);
      chk(row_addr, 6'd54);
      chk(col_addr, 7'd72);
      setctrl(32'h0);
      chk(row_addr, 6'd5);
      chk(col_addr, 7'd7);
      $display("mirror test done");
   endtask
   task automatic t_trim();
      setctrl(32'h0f80);
      chk({tdir, tsteps}, {1'b1, tof_mod_pkg::TRIM_MAX});
      setctrl(32'h0520);
      chk({tdir, tsteps, pdc}, {1'b0, 4'h5, 1'b1});
      $display("trim test done");
   endtask
   task automatic t_quads();
      setctrl(32'h0);
      quad();
      setctrl(32'h4);
      quad();
      setctrl(32'h1c);
      quad();
      setctrl(32'h44);
      quad();
      seqd = 8'h1b;
      apb(1'b1, tof_mod_pkg::OFS_SEQ_D, {24'h0, seqd});
      setctrl(32'h5004);
      quad();
      quad();
      @(posedge clk_sys);
      dealias_frame <= 1'b1;
      quad();
      quad();
      @(posedge clk_sys);
      dealias_frame <= 1'b0;
      $display("quad test done");
   endtask
   task automatic t_pll();
      logic seen;
      seen = 1'b0;
      apb(1'b1, tof_mod_pkg::OFS_PLL, 32'h0001_0114);
      apb(1'b1, tof_mod_pkg::OFS_FRAC, 32'h8000);
      setctrl(32'h1_0000);
      chk(pll_active, {8'h10, 16'h0, 4'h1, 4'h1});
      ctrl_v = 32'h0;
      apb(1'b1, tof_mod_pkg::OFS_CTRL, 32'h0);
      repeat (4) begin
         @(posedge clk_sys);
         if (pll_load === 1'b1) seen = 1'b1;
      end
      chk(seen, 1'b1);
      chk(pll_active, {8'h14, 16'h8000, 4'h1, 4'h1});
      chk(eff_mult, 24'h14_8000);
      $display("pll apply test done");
   endtask

   // ==========================================
   // main sequence
   initial begin
      {psel, penable, pwrite, quad_start, readout_done, dealias_frame} = 6'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      row_in = 6'h0;
      col_in = 7'h0;
      integ_cycles = 16'd40;
      seqb = tof_mod_pkg::SEQ_RST;
      seqd = tof_mod_pkg::SEQ_RST;
      ctrl_v = 32'h0;
      rst = 1'b1;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      t_regs();
      t_mirror();
      t_trim();
      t_quads();
      t_pll();
      stop_test();
   end
endmodule

bind tof_mod_ctrl tof_mod_ctrl_assertions #(.ROWS(ROWS), .COLS(COLS)) chk_i (
   .clk_sys, .rst, .quad_start, .shutter_on, .pixel_demod_en, .light, .duty_trim_steps, .phase_sel,
   .phase_deg, .row_in, .col_in, .row_addr, .col_addr, .pll_active, .pll_load);

// ==== tof_mod_ctrl.sv ====
// modulation, shutter and readout-direction control with apb registers
// assumes frame timing, the pll and readout engine sit outside on clk_sys
//
// Behaviour
// - vertical mirror set reads rows in reverse order
// - horizontal mirror set reads columns in reverse order
// - shutter enabled: on in reset and integration, off otherwise
// - shutter disabled: switch stays on in every quad state
// - shutter enable resets to 0, writing 1 enables it
// - phase steps automatically per quad, four quads per frequency
// - hopping offsets quad order on alternate sub-frames
// - phase is 360 times the sequence entry picked by effective quad over quads per frequency
// - base and de-aliasing phase sequences are separately programmable
// - positive drive toggles only in integration, low otherwise
// - negative drive toggles only in integration, high otherwise
// - driver enable rises before integration, falls just after it
// - preassert raises driver enable 15 us before integration
// - hold freezes drives at static level and its complement
// - trim direction 0 lengthens positive duty, 1 shortens it
// - duty trim steps about 450 ps, at most 11
// - base tone is 24 MHz times multiplier over divider chain
// - effective multiplier is integer plus fraction over 2^16
// - reset gives multiplier 16, fraction 0, divider 1, prescaler 1
// - settings apply when the apply bit goes 1 then 0
// - sensor reset lasts 720 clocks before integration
`timescale 1ns/10ps
module tof_mod_ctrl #(
   parameter int ROWS = 60,
   parameter int COLS = 80
) (
   // clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 rst,
   // apb slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic [31:0]               prdata,
   output logic                      pready,
   output logic                      pslverr,
   // frame timing
   input  wire logic                 quad_start,
   input  wire logic [15:0]          integ_cycles,
   input  wire logic                 readout_done,
   input  wire logic                 dealias_frame,
   // readout addressing
   input  wire logic [5:0]           row_in,
   input  wire logic [6:0]           col_in,
   output logic [5:0]                row_addr,
   output logic [6:0]                col_addr,
   // pixel and light drive
   input  wire logic                 tone,
   output logic                      shutter_on,
   output logic                      pixel_demod_en,
   output logic                      pixel_drive_dc_level,
   output tof_mod_pkg::light_out_t   light,
   output logic                      duty_trim_direction,
   output logic [3:0]                duty_trim_steps,
   // phase selection
   output logic [1:0]                phase_sel,
   output logic [8:0]                phase_deg,
   // pll configuration
   output tof_mod_pkg::pll_cfg_t     pll_active,
   output logic [23:0]               eff_multiplier,
   output logic                      pll_load
);

   // ======================================
   // registers
   logic [31:0]            ctrl;
   logic [7:0]             pll_multiplier;
   logic [3:0]             pll_divider;
   logic [3:0]             tone_prescaler;
   logic [15:0]            pll_multiplier_fraction;
   logic [7:0]             seq_base;
   logic [7:0]             seq_alias;
   logic                   apply_seen;
   tof_mod_pkg::quad_state_t state;
   logic [15:0]            cnt;
   logic [1:0]             quad_idx;
   logic                   odd_sub;
   logic                   integ_d;
   logic                   drv_en;

   logic                   wr;
   logic                   rd;
   logic                   hit;
   logic                   apply_bit;
   logic [3:0]             trim_req;
   logic [1:0]             eff_quad;
   logic [7:0]             seq_sel;
   logic                   in_integ;
   logic                   pre_win;

   // ======================================
   // apb decode
   assign wr = psel & penable & pwrite;
   assign rd = psel & ~penable;
   assign pready = 1'b1;
   assign hit = paddr inside {tof_mod_pkg::OFS_CTRL, tof_mod_pkg::OFS_PLL,
                              tof_mod_pkg::OFS_FRAC, tof_mod_pkg::OFS_SEQ_B,
                              tof_mod_pkg::OFS_SEQ_D, tof_mod_pkg::OFS_STATUS,
                              tof_mod_pkg::OFS_ACTIVE};
   assign pslverr = psel & penable & ~hit;
   assign apply_bit = pwdata[tof_mod_pkg::B_APPLY];
   assign trim_req = pwdata[tof_mod_pkg::B_TRIM +: 4];

   // ======================================
   // control register
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrl <= 32'h0000_0000;
      end else if (wr && paddr == tof_mod_pkg::OFS_CTRL) begin
         ctrl <= pwdata & 32'h0001_ffff;
         // larger counts are not programmable, so clamp
         if (trim_req > tof_mod_pkg::TRIM_MAX) begin
            ctrl[tof_mod_pkg::B_TRIM +: 4] <= tof_mod_pkg::TRIM_MAX;
         end
      end
   end

   // ======================================
   // staged pll settings and phase sequences
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pll_multiplier          <= tof_mod_pkg::MULT_RST;
         pll_divider             <= tof_mod_pkg::DIV_RST;
         tone_prescaler          <= tof_mod_pkg::PS_RST;
         pll_multiplier_fraction <= tof_mod_pkg::FRAC_RST;
         seq_base                <= tof_mod_pkg::SEQ_RST;
         seq_alias               <= tof_mod_pkg::SEQ_RST;
      end else if (wr) begin
         unique case (paddr)
            tof_mod_pkg::OFS_PLL: begin
               pll_multiplier <= pwdata[tof_mod_pkg::B_MULT +: 8];
               pll_divider    <= pwdata[tof_mod_pkg::B_DIV +: 4];
               tone_prescaler <= pwdata[tof_mod_pkg::B_PS +: 4];
            end
            tof_mod_pkg::OFS_FRAC: begin
               pll_multiplier_fraction <= pwdata[15:0];
            end
            tof_mod_pkg::OFS_SEQ_B: begin
               seq_base <= pwdata[7:0];
            end
            tof_mod_pkg::OFS_SEQ_D: begin
               seq_alias <= pwdata[7:0];
            end
            default: begin
            end
         endcase
      end
   end

   // ======================================
   // apply sequence: copy staged set only on 1 then 0
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         apply_seen <= 1'b0;
         pll_load   <= 1'b0;
         pll_active <= '{mult: tof_mod_pkg::MULT_RST,
                         frac: tof_mod_pkg::FRAC_RST,
                         div:  tof_mod_pkg::DIV_RST,
                         ps:   tof_mod_pkg::PS_RST};
      end else begin
         pll_load <= 1'b0;
         if (wr && paddr == tof_mod_pkg::OFS_CTRL) begin
            if (apply_bit) begin
               apply_seen <= 1'b1;
            end else if (apply_seen) begin
               apply_seen <= 1'b0;
               pll_load   <= 1'b1;
               // half-written values never reach the pll
               pll_active <= '{mult: pll_multiplier,
                               frac: pll_multiplier_fraction,
                               div:  pll_divider,
                               ps:   tone_prescaler};
            end
         end
      end
   end

   // fixed point 8.16 multiplier for the pll
   assign eff_multiplier = {pll_active.mult, pll_active.frac};

   // ======================================
   // read mux
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (rd) begin
         unique case (paddr)
            tof_mod_pkg::OFS_CTRL: prdata <= ctrl;
            tof_mod_pkg::OFS_PLL: prdata <= {12'h000, tone_prescaler,
                                             4'h0, pll_divider,
                                             pll_multiplier};
            tof_mod_pkg::OFS_FRAC: prdata <= {16'h0000,
                                              pll_multiplier_fraction};
            tof_mod_pkg::OFS_SEQ_B: prdata <= {24'h000000, seq_base};
            tof_mod_pkg::OFS_SEQ_D: prdata <= {24'h000000, seq_alias};
            tof_mod_pkg::OFS_STATUS: prdata <= {16'h0000, 5'h00, drv_en,
                                                shutter_on, odd_sub,
                                                quad_idx, eff_quad,
                                                state == tof_mod_pkg::Q_DEAD,
                                                state == tof_mod_pkg::Q_READ,
                                                state == tof_mod_pkg::Q_INTEG,
                                                state == tof_mod_pkg::Q_RESET};
            tof_mod_pkg::OFS_ACTIVE: prdata <= {12'h000, pll_active.ps,
                                                4'h0, pll_active.div,
                                                pll_active.mult};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ======================================
   // quad sequencer
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state <= tof_mod_pkg::Q_IDLE;
         cnt   <= 16'h0000;
      end else begin
         unique case (state)
            tof_mod_pkg::Q_IDLE, tof_mod_pkg::Q_DEAD: begin
               if (quad_start) begin
                  state <= tof_mod_pkg::Q_RESET;
                  cnt   <= 16'h0000;
               end
            end
            tof_mod_pkg::Q_RESET: begin
               if (cnt == 16'(tof_mod_pkg::RESET_CYC - 1)) begin
                  state <= tof_mod_pkg::Q_INTEG;
                  cnt   <= 16'h0000;
               end else begin
                  cnt <= cnt + 16'h0001;
               end
            end
            tof_mod_pkg::Q_INTEG: begin
               if (cnt + 16'h0001 >= integ_cycles) begin
                  state <= tof_mod_pkg::Q_READ;
               end else begin
                  cnt <= cnt + 16'h0001;
               end
            end
            tof_mod_pkg::Q_READ: begin
               if (readout_done) begin
                  state <= tof_mod_pkg::Q_DEAD;
               end
            end
         endcase
      end
   end

   // quad index advances at each readout end, sub-frame parity after every fourth
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         quad_idx <= 2'h0;
         odd_sub  <= 1'b0;
      end else if (state == tof_mod_pkg::Q_READ && readout_done) begin
         quad_idx <= quad_idx + 2'h1;
         if (quad_idx == 2'(tof_mod_pkg::QUADS - 1)) begin
            odd_sub <= ~odd_sub;
         end
      end
   end

   // ======================================
   // phase selection
   function automatic logic [8:0] deg_of(input logic [1:0] q);
      deg_of = 9'(360 * int'(q) / tof_mod_pkg::QUADS);
   endfunction

   assign eff_quad = quad_idx + ((ctrl[tof_mod_pkg::B_HOP] && odd_sub) ?
                     ctrl[tof_mod_pkg::B_HOFS +: 2] : 2'h0);
   assign seq_sel  = dealias_frame ? seq_alias : seq_base;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         phase_sel <= 2'h0;
         phase_deg <= 9'h000;
      end else begin
         phase_sel <= seq_sel[2*eff_quad +: 2];
         phase_deg <= deg_of(seq_sel[2*eff_quad +: 2]);
      end
   end

   // ======================================
   // shutter and readout direction
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         shutter_on <= 1'b1;
         row_addr   <= 6'h00;
         col_addr   <= 7'h00;
      end else begin
         if (ctrl[tof_mod_pkg::B_SHUT]) begin
            shutter_on <= state == tof_mod_pkg::Q_RESET ||
                          state == tof_mod_pkg::Q_INTEG;
         end else begin
            shutter_on <= 1'b1;
         end
         row_addr <= ctrl[tof_mod_pkg::B_VMIR] ?
                     6'(ROWS - 1) - row_in : row_in;
         col_addr <= ctrl[tof_mod_pkg::B_HMIR] ?
                     7'(COLS - 1) - col_in : col_in;
      end
   end

   // ======================================
   // light driver enable
   assign in_integ = state == tof_mod_pkg::Q_INTEG;
   // counting within the reset phase keeps the lead fixed at 375 clocks
   assign pre_win = state == tof_mod_pkg::Q_RESET &&
                    (ctrl[tof_mod_pkg::B_PRE] ?
                     cnt >= 16'(tof_mod_pkg::RESET_CYC -
                                tof_mod_pkg::PREASSERT_CYC) :
                     cnt == 16'(tof_mod_pkg::RESET_CYC - 1));

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         integ_d <= 1'b0;
         drv_en  <= 1'b0;
      end else begin
         integ_d <= in_integ;
         drv_en  <= pre_win | in_integ;
      end
   end

   // ======================================
   // light and pixel drive
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pixel_demod_en       <= 1'b0;
         pixel_drive_dc_level <= 1'b0;
         duty_trim_direction  <= 1'b0;
         duty_trim_steps      <= 4'h0;
      end else begin
         pixel_demod_en       <= in_integ & ~ctrl[tof_mod_pkg::B_HOLD];
         pixel_drive_dc_level <= ctrl[tof_mod_pkg::B_PDC];
         duty_trim_direction  <= ctrl[tof_mod_pkg::B_TDIR];
         duty_trim_steps      <= ctrl[tof_mod_pkg::B_TRIM +: 4];
      end
   end

   // tone passes straight through; resampling it at clk_sys would alias
   always_comb begin
      light.active = drv_en | integ_d;
      if (!integ_d) begin
         light.pos = 1'b0;
         light.neg = 1'b1;
      end else if (ctrl[tof_mod_pkg::B_HOLD]) begin
         light.pos = ctrl[tof_mod_pkg::B_LDC];
         light.neg = ~ctrl[tof_mod_pkg::B_LDC];
      end else begin
         light.pos = tone;
         light.neg = ~tone;
      end
   end

   // frequency division lives in the pll; software bounds

endmodule

// ==== tof_mod_ctrl_assertions.sv ====
// checker: port-level properties of the modulation controller
// assumes it is bound onto tof_mod_ctrl, one clk_sys domain
`timescale 1ns/10ps
module tof_mod_ctrl_assertions #(
   parameter int ROWS = 60,
   parameter int COLS = 80
) (
   // clock and reset
   input wire logic                    clk_sys,
   input wire logic                    rst,
   // quad timing and drive
   input wire logic                    quad_start,
   input wire logic                    shutter_on,
   input wire logic                    pixel_demod_en,
   input wire tof_mod_pkg::light_out_t light,
   input wire logic [3:0]              duty_trim_steps,
   input wire logic [1:0]              phase_sel,
   input wire logic [8:0]              phase_deg,
   // addressing
   input wire logic [5:0]              row_in,
   input wire logic [6:0]              col_in,
   input wire logic [5:0]              row_addr,
   input wire logic [6:0]              col_addr,
   // pll
   input wire tof_mod_pkg::pll_cfg_t   pll_active,
   input wire logic                    pll_load
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   // ==========================================
   // quad start steps
   sequence start_s;
      quad_start && !light.active;
   endsequence
   sequence quiet_s;
      !light.active [*8];
   endsequence

   // ==========================================
   // properties
   sensor_reset_a: assert property (start_s |=> quiet_s)
      else $error("driver enable rose in sensor reset");
   idle_drive_a: assert property (!light.active |-> !light.pos && light.neg)
      else $error("light drive not at rest level");
   integ_enable_a: assert property (pixel_demod_en |-> light.active)
      else $error("driver enable low in integration");
   integ_shutter_a: assert property (pixel_demod_en |-> shutter_on)
      else $error("shutter off in integration");
   phase_value_a: assert property (phase_deg == 9'd90 * phase_sel)
      else $error("phase degrees wrong");
   trim_limit_a: assert property (duty_trim_steps <= tof_mod_pkg::TRIM_MAX)
      else $error("trim steps above limit");
   pll_hold_a: assert property ($changed(pll_active) |-> (pll_load || $past(pll_load)) or ##1 pll_load)
      else $error("active pll set changed without load");
   load_pulse_a: assert property (pll_load |=> !pll_load)
      else $error("load pulse longer than one cycle");
   row_mirror_a: assert property (row_addr == $past(row_in) || row_addr == 6'(ROWS - 1) - $past(row_in))
      else $error("row address neither direct nor mirrored");
   col_mirror_a: assert property (col_addr == $past(col_in) || col_addr == 7'(COLS - 1) - $past(col_in))
      else $error("column address neither direct nor mirrored");
endmodule

// ==== tof_mod_pkg.sv ====
// constants and carriers for the modulation / shutter controller
// assumes a 25 MHz system clock and a 32-bit apb register bus
package tof_mod_pkg;

   // ======================================
   // register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_PLL    = 8'h04;
   localparam logic [7:0] OFS_FRAC   = 8'h08;
   localparam logic [7:0] OFS_SEQ_B  = 8'h0c;
   localparam logic [7:0] OFS_SEQ_D  = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_ACTIVE = 8'h18;

   // ======================================
   // ctrl fields
   localparam int B_VMIR    = 0;
   localparam int B_HMIR    = 1;
   localparam int B_SHUT    = 2;
   localparam int B_HOLD    = 3;
   localparam int B_LDC     = 4;
   localparam int B_PDC     = 5;
   localparam int B_PRE     = 6;
   localparam int B_TDIR    = 7;
   localparam int B_TRIM    = 8;
   localparam int B_HOP     = 12;
   localparam int B_HOFS    = 13;
   localparam int B_APPLY   = 16;
   // pll fields
   localparam int B_MULT    = 0;
   localparam int B_DIV     = 8;
   localparam int B_PS      = 16;

   // ======================================
   // reset values and limits
   localparam logic [7:0]  MULT_RST = 8'h10;
   localparam logic [15:0] FRAC_RST = 16'h0000;
   localparam logic [3:0]  DIV_RST  = 4'h1;
   localparam logic [3:0]  PS_RST   = 4'h1;
   localparam logic [7:0]  SEQ_RST  = 8'he4;
   localparam logic [3:0]  TRIM_MAX = 4'hb;

   // ======================================
   // timing
   localparam int CLK_MHZ      = 25;
   localparam int RESET_CYC    = 720;
   localparam int PREASSERT_NS = 15000;
   localparam int PREASSERT_CYC = (PREASSERT_NS * CLK_MHZ + 999) / 1000;
   localparam int QUADS        = 4;

   typedef enum {
      Q_IDLE, Q_RESET, Q_INTEG, Q_READ, Q_DEAD
   } quad_state_t;

   typedef struct packed {
      logic [7:0]  mult;
      logic [15:0] frac;
      logic [3:0]  div;
      logic [3:0]  ps;
   } pll_cfg_t;

   typedef struct packed {
      logic pos;
      logic neg;
      logic active;
   } light_out_t;

endpackage
